// ### verilog/mwm_pkg.sv
/*
 * Package of the motion window monitor: dictionary indices, preset values,
 * operating-mode codes and millisecond timing.
 * Assumes a 20 MHz device clock.
 */
package mwm_pkg;
    // Dictionary indices
    localparam logic [15:0] MWM_IDX_POS_WINDOW = 16'h6067;
    localparam logic [15:0] MWM_IDX_POS_DWELL = 16'h6068;
    localparam logic [15:0] MWM_IDX_VEL_DEMAND = 16'h606B;
    localparam logic [15:0] MWM_IDX_VEL_ACTUAL = 16'h606C;
    localparam logic [15:0] MWM_IDX_VEL_WINDOW = 16'h606D;
    localparam logic [15:0] MWM_IDX_VEL_DWELL = 16'h606E;
    localparam logic [15:0] MWM_IDX_THR_LEVEL = 16'h606F;
    localparam logic [15:0] MWM_IDX_THR_TIME = 16'h6070;

    // Preset values
    localparam logic [31:0] MWM_RST_POS_WINDOW = 32'h0000000A;
    localparam logic [15:0] MWM_RST_POS_DWELL = 16'h0064;
    localparam logic [15:0] MWM_RST_VEL_WINDOW = 16'h001E;
    localparam logic [15:0] MWM_RST_VEL_DWELL = 16'h0000;
    localparam logic [15:0] MWM_RST_THR_LEVEL = 16'h0000;
    localparam logic [15:0] MWM_RST_THR_TIME = 16'h0000;

    // Window value that switches position monitoring off
    localparam logic [31:0] MWM_POS_WINDOW_OFF = 32'h0FFFFFFF;

    // Operating-mode codes presented on i_mode
    localparam logic [7:0] MWM_MODE_PROFILE_POS = 8'h01;
    localparam logic [7:0] MWM_MODE_PROFILE_VEL = 8'h03;
    localparam logic [7:0] MWM_MODE_INTERP_POS = 8'h07;

    // Status word bit positions
    localparam int MWM_SW_TARGET_BIT = 10;
    localparam int MWM_SW_SPEED_BIT = 12;

    // Dwell channels
    localparam int MWM_CH_POS = 0;
    localparam int MWM_CH_VEL = 1;
    localparam int MWM_CH_THR = 2;
    localparam int MWM_NCH = 3;

    // Millisecond tick
    localparam int MWM_CLK_PERIOD_NS = 50;
    localparam int MWM_TICK_NS = 1000000;
    localparam int MWM_TICK_CYCLES = MWM_TICK_NS / MWM_CLK_PERIOD_NS;
endpackage : mwm_pkg

// ### verilog/mwm_top.sv
/*
 * Motion window monitor: target-reached and speed-nonzero flags with
 * millisecond dwell timing, plus its dictionary objects.
 * Assumes the drive core presents positions, speeds, ramp output and the
 * operating mode synchronously to i_mclk, and that the fieldbus stack
 * issues one-cycle object read/write strobes.
 */
// Notes on behaviour
// - Position modes: target-reached set when position error below position window.
// - Position condition must hold longer than position dwell milliseconds; preset 0x64.
// - Position monitoring applies in profile position and interpolated position modes.
// - Position window written with the off pattern disables position monitoring.
// - Profile velocity: target-reached set when speed error below velocity window, preset 0x1E.
// - Velocity condition must hold longer than velocity dwell milliseconds; preset zero.
// - Speed above threshold for threshold time drives speed-nonzero bit to 0.
// - Otherwise the speed-nonzero bit stays at 1.
// - Ramp output reported as velocity demand and used as velocity setpoint.
module mwm_top
    import mwm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MWM_TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [7:0] i_mode,
    input wire logic signed [31:0] i_pos_actual,
    input wire logic signed [31:0] i_pos_target,
    input wire logic signed [31:0] i_vel_actual,
    input wire logic signed [31:0] i_ramp_out,
    input wire logic [15:0] i_obj_index,
    input wire logic i_obj_rd,
    input wire logic i_obj_wr,
    input wire logic [31:0] i_obj_wdata,
    output logic [31:0] o_obj_rdata,
    output logic o_obj_ack,
    output logic o_obj_err,
    output logic o_target_reached,
    output logic o_speed_nonzero_n,
    output logic signed [31:0] o_vel_setpoint
);

    logic [31:0] pos_window_q;
    logic [15:0] pos_dwell_q;
    logic [15:0] vel_window_q;
    logic [15:0] vel_dwell_q;
    logic [15:0] thr_level_q;
    logic [15:0] thr_time_q;
    logic signed [31:0] vel_demand_q;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic signed [32:0] pos_diff;
    logic signed [32:0] vel_diff;
    logic [32:0] pos_err;
    logic [32:0] vel_err;
    logic [32:0] vel_mag;
    logic pos_mode;
    logic vel_mode;
    logic [MWM_NCH-1:0] cond;
    logic [MWM_NCH-1:0] met;
    logic [15:0] lim [MWM_NCH];
    logic tick_wrap;
    logic idx_known;
    logic idx_writable;
    logic wr_take;
    logic wr_pos_window;
    logic wr_pos_dwell;
    logic wr_vel_window;
    logic wr_vel_dwell;
    logic wr_thr_level;
    logic wr_thr_time;
    logic [31:0] rd_data;

    // Millisecond tick
    assign tick_wrap = (tick_cnt_q >= TICK_CYCLES - 1);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt_q <= 32'h00000000;
        end else if (tick_wrap) begin
            tick_cnt_q <= 32'h00000000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
        end
    end

    // Registered so every dwell counter sees the same one-cycle pulse
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_wrap;
        end
    end

    // Absolute errors on a 33-bit signed difference so no input pair overflows
    always_comb begin
        pos_diff = 33'(i_pos_actual) - 33'(i_pos_target);
        vel_diff = 33'(i_vel_actual) - 33'(i_ramp_out);
        pos_err = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
        vel_err = vel_diff[32] ? 33'(-vel_diff) : 33'(vel_diff);
        vel_mag = i_vel_actual[31] ? 33'(-33'(i_vel_actual)) : 33'(33'(i_vel_actual));
    end

    // Mode decode; any other code keeps both target windows idle
    assign pos_mode = (i_mode == MWM_MODE_PROFILE_POS) || (i_mode == MWM_MODE_INTERP_POS);
    assign vel_mode = (i_mode == MWM_MODE_PROFILE_VEL);

    assign cond[MWM_CH_POS] = pos_mode && (pos_window_q != MWM_POS_WINDOW_OFF)
        && (pos_err < {1'b0, pos_window_q});
    assign cond[MWM_CH_VEL] = vel_mode && (vel_err < {17'h00000, vel_window_q});
    // Threshold sense is taken in every mode, unlike the target windows
    assign cond[MWM_CH_THR] = vel_mag > {17'h00000, thr_level_q};

    // Per-channel dwell limits feed the counters below
    assign lim[MWM_CH_POS] = pos_dwell_q;
    assign lim[MWM_CH_VEL] = vel_dwell_q;
    assign lim[MWM_CH_THR] = thr_time_q;

    // One dwell counter per channel, counting whole milliseconds of the condition
    for (genvar ch = 0; ch < MWM_NCH; ch++) begin : g_dwell
        logic [16:0] cnt_q;
        // Saturates so a long dwell never wraps back below the limit
        always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
                cnt_q <= 17'h00000;
            end else if (!cond[ch]) begin
                cnt_q <= 17'h00000;
            end else if (tick_q && !cnt_q[16]) begin
                cnt_q <= cnt_q + 17'h00001;
            end
        end
        // Target channels need strictly longer than the time; threshold needs the time itself
        if (ch == MWM_CH_THR) begin : g_ge
            assign met[ch] = cond[ch] && (cnt_q >= {1'b0, lim[ch]});
        end else begin : g_gt
            assign met[ch] = cond[ch] && (cnt_q > {1'b0, lim[ch]});
        end
    end

    // Status word bits; the modes are exclusive, so one target bit serves both windows
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_target_reached <= 1'b0;
        end else begin
            o_target_reached <= met[MWM_CH_POS] || met[MWM_CH_VEL];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_speed_nonzero_n <= 1'b1;
        end else begin
            o_speed_nonzero_n <= !met[MWM_CH_THR];
        end
    end

    // Ramp output as demand value and velocity setpoint
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            vel_demand_q <= 32'sh00000000;
        end else begin
            vel_demand_q <= i_ramp_out;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_vel_setpoint <= 32'sh00000000;
        end else begin
            o_vel_setpoint <= i_ramp_out;
        end
    end

    // Index decode for the error answer of reads and writes; the write strobes compare the index themselves
    always_comb begin
        idx_known = 1'b0;
        idx_writable = 1'b0;
        case (i_obj_index)
            MWM_IDX_POS_WINDOW,
            MWM_IDX_POS_DWELL,
            MWM_IDX_VEL_WINDOW,
            MWM_IDX_VEL_DWELL,
            MWM_IDX_THR_LEVEL,
            MWM_IDX_THR_TIME: begin
                idx_known = 1'b1;
                idx_writable = 1'b1;
            end
            MWM_IDX_VEL_DEMAND,
            MWM_IDX_VEL_ACTUAL: begin
                idx_known = 1'b1;
                idx_writable = 1'b0;
            end
            default: begin
                idx_known = 1'b0;
                idx_writable = 1'b0;
            end
        endcase
    end

    // A read strobe wins over a simultaneous write, so the object is left alone
    assign wr_take = i_obj_wr && !i_obj_rd;
    assign wr_pos_window = wr_take && (i_obj_index == MWM_IDX_POS_WINDOW);
    assign wr_pos_dwell = wr_take && (i_obj_index == MWM_IDX_POS_DWELL);
    assign wr_vel_window = wr_take && (i_obj_index == MWM_IDX_VEL_WINDOW);
    assign wr_vel_dwell = wr_take && (i_obj_index == MWM_IDX_VEL_DWELL);
    assign wr_thr_level = wr_take && (i_obj_index == MWM_IDX_THR_LEVEL);
    assign wr_thr_time = wr_take && (i_obj_index == MWM_IDX_THR_TIME);

    // Writable objects; read-only and unknown indices never reach these
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pos_window_q <= MWM_RST_POS_WINDOW;
        end else if (wr_pos_window) begin
            pos_window_q <= i_obj_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pos_dwell_q <= MWM_RST_POS_DWELL;
        end else if (wr_pos_dwell) begin
            pos_dwell_q <= i_obj_wdata[15:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            vel_window_q <= MWM_RST_VEL_WINDOW;
        end else if (wr_vel_window) begin
            vel_window_q <= i_obj_wdata[15:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            vel_dwell_q <= MWM_RST_VEL_DWELL;
        end else if (wr_vel_dwell) begin
            vel_dwell_q <= i_obj_wdata[15:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            thr_level_q <= MWM_RST_THR_LEVEL;
        end else if (wr_thr_level) begin
            thr_level_q <= i_obj_wdata[15:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            thr_time_q <= MWM_RST_THR_TIME;
        end else if (wr_thr_time) begin
            thr_time_q <= i_obj_wdata[15:0];
        end
    end

    // Read multiplexer; 16-bit objects read back zero-extended
    // Actual speed is read live, not captured, so a read shows this cycle's value
    always_comb begin
        rd_data = 32'h00000000;
        case (i_obj_index)
            MWM_IDX_POS_WINDOW: rd_data = pos_window_q;
            MWM_IDX_POS_DWELL: rd_data = {16'h0000, pos_dwell_q};
            MWM_IDX_VEL_DEMAND: rd_data = vel_demand_q;
            MWM_IDX_VEL_ACTUAL: rd_data = i_vel_actual;
            MWM_IDX_VEL_WINDOW: rd_data = {16'h0000, vel_window_q};
            MWM_IDX_VEL_DWELL: rd_data = {16'h0000, vel_dwell_q};
            MWM_IDX_THR_LEVEL: rd_data = {16'h0000, thr_level_q};
            MWM_IDX_THR_TIME: rd_data = {16'h0000, thr_time_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    // Access answer, one cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_obj_ack <= 1'b0;
        end else begin
            o_obj_ack <= i_obj_rd || i_obj_wr;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_obj_err <= 1'b0;
        end else begin
            o_obj_err <= (i_obj_rd && !idx_known) || (wr_take && !idx_writable);
        end
    end

    // Data holds until the next access; writes and refused reads return zero
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_obj_rdata <= 32'h00000000;
        end else if (i_obj_rd) begin
            o_obj_rdata <= rd_data;
        end else if (i_obj_wr) begin
            o_obj_rdata <= 32'h00000000;
        end
    end

endmodule // mwm_top

// ### tb/mwm_monitor.sv
/* Port checker of the motion window monitor: object handshake and status flags.
   Bound to mwm_top by the bench; one clock domain. */
module mwm_monitor
    import mwm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [7:0] i_mode,
    input wire logic signed [31:0] i_vel_actual,
    input wire logic signed [31:0] i_ramp_out,
    input wire logic [15:0] i_obj_index,
    input wire logic i_obj_rd,
    input wire logic i_obj_wr,
    input wire logic [31:0] o_obj_rdata,
    input wire logic o_obj_ack,
    input wire logic o_obj_err,
    input wire logic o_target_reached,
    input wire logic o_speed_nonzero_n,
    input wire logic signed [31:0] o_vel_setpoint
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic signed [32:0] verr = 33'(i_vel_actual) - 33'(i_ramp_out);
    // Error beyond any 16-bit window can never count as reached
    wire logic vel_far = (i_mode == MWM_MODE_PROFILE_VEL) && (verr > 33'sh0FFFF || verr < -33'sh0FFFF);
    wire logic off_mode = !(i_mode inside {MWM_MODE_PROFILE_POS, MWM_MODE_PROFILE_VEL,
        MWM_MODE_INTERP_POS});
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    ack_after_strobe_a: assert property ((i_obj_rd || i_obj_wr) |=> o_obj_ack)
        else $error("no ack after strobe");
    ack_cause_a: assert property (o_obj_ack |-> $past(i_obj_rd || i_obj_wr))
        else $error("ack without strobe");
    err_with_ack_a: assert property (o_obj_err |-> o_obj_ack && o_obj_rdata == 32'h0)
        else $error("error flag outside ack or with data");
    demand_ro_a: assert property (i_obj_wr && !i_obj_rd && i_obj_index == MWM_IDX_VEL_DEMAND |=> o_obj_err)
        else $error("write to demand not refused");
    setpoint_copy_a: assert property ($past(i_resetn) |-> o_vel_setpoint == $past(i_ramp_out))
        else $error("setpoint not ramp output");
    target_mode_a: assert property (off_mode |=> !o_target_reached)
        else $error("target flag in other mode");
    vel_outside_a: assert property (vel_far |=> !o_target_reached)
        else $error("target flag with speed far off");
    speed_idle_a: assert property (i_vel_actual == 32'sh0 |=> o_speed_nonzero_n)
        else $error("speed flag low at standstill");
endmodule // mwm_monitor

// ### tb/mwm_master.sv
/* Fieldbus master model: one-cycle object read and write strobes.
   Assumes the bench calls it just after a rising edge. */
module mwm_master (
    input wire logic i_mclk,
    output logic o_rd,
    output logic o_wr,
    output logic [15:0] o_index,
    output logic [31:0] o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_index = 16'h0;
        o_wdata = 32'h0;
    end
    // Strobe stays up for back-to-back calls; idle releases it
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        o_rd = !wr;
        o_wr = wr;
        o_index = idx;
        o_wdata = wd;
        @(posedge i_mclk);
        #2;
    endtask
    // Released lines show no stale value
    task automatic idle();
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_index = ~o_index;
        o_wdata = ~o_wdata;
    endtask
endmodule // mwm_master

// ### tb/tb.sv
/* Bench of the motion window monitor: object accesses, dwell timing, flags.
   Assumes mwm_pkg, mwm_top, mwm_master and mwm_monitor are compiled first. */
module tb
    import mwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TK = 4;
    typedef struct packed {logic [31:0] data; logic err;} mwm_exp_t;
    mwm_exp_t exq[$];
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] mode = 8'h00;
    logic signed [31:0] pos_act = 32'sh0, pos_tgt = 32'sh1388, vel_act = 32'sh0, ramp = 32'sh0;
    logic rd, wr, ack, err, tgt, nz_n;
    logic [15:0] idx;
    logic [31:0] wd, rdata, rv;
    logic signed [31:0] setp;
    int n_mismatch = 0, n_tests = 0;
    int voff[3] = '{32'sh1D, -32'sh1D, 32'sh1E};
    logic [7:0] pmode[3] = '{MWM_MODE_INTERP_POS, MWM_MODE_PROFILE_VEL, MWM_MODE_PROFILE_POS};
    always #25 i_mclk = ~i_mclk;
    mwm_top #(.TICK_CYCLES(TK)) dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_mode(mode),
        .i_pos_actual(pos_act), .i_pos_target(pos_tgt), .i_vel_actual(vel_act),
        .i_ramp_out(ramp), .i_obj_index(idx), .i_obj_rd(rd), .i_obj_wr(wr), .i_obj_wdata(wd),
        .o_obj_rdata(rdata), .o_obj_ack(ack), .o_obj_err(err), .o_target_reached(tgt),
        .o_speed_nonzero_n(nz_n), .o_vel_setpoint(setp));
    mwm_master m_u (.i_mclk(i_mclk), .o_rd(rd), .o_wr(wr), .o_index(idx), .o_wdata(wd));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    task automatic obj(input logic w, input logic [15:0] i, input logic [31:0] d,
        input logic [31:0] e, input logic er);
        exq.push_back('{e, er});
        m_u.access(w, i, d);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Ack and data are registered, so the falling edge sees them settled
    always @(negedge i_mclk) begin
        if (ack === 1'b1) begin
            if (exq.size() == 0) begin
                n_mismatch++;
                $display("mismatch ack expected 0 seen 1");
            end else begin
                chk("rdata", exq[0].data, rdata);
                chk("err", {31'h0, exq[0].err}, {31'h0, err});
                void'(exq.pop_front());
            end
        end
    end
    initial begin
        #(3000 * 50);
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(35));
        ramp = $urandom;
        wt(16);
        i_resetn = 1'b1;
        wt(2);
        obj(1'b0, MWM_IDX_POS_WINDOW, 32'h0, 32'h0000000A, 1'b0);
        obj(1'b0, MWM_IDX_POS_DWELL, 32'h0, 32'h00000064, 1'b0);
        obj(1'b0, MWM_IDX_VEL_WINDOW, 32'h0, 32'h0000001E, 1'b0);
        obj(1'b0, MWM_IDX_VEL_DWELL, 32'h0, 32'h0, 1'b0);
        obj(1'b0, MWM_IDX_THR_LEVEL, 32'h0, 32'h0, 1'b0);
        obj(1'b0, MWM_IDX_THR_TIME, 32'h0, 32'h0, 1'b0);
        obj(1'b0, MWM_IDX_VEL_DEMAND, 32'h0, ramp, 1'b0);
        obj(1'b1, MWM_IDX_VEL_ACTUAL, 32'h5, 32'h0, 1'b1);
        obj(1'b1, MWM_IDX_VEL_DEMAND, 32'h5, 32'h0, 1'b1);
        obj(1'b1, 16'h6071, 32'h5, 32'h0, 1'b1);
        obj(1'b0, 16'h6071, 32'h0, 32'h0, 1'b1);
        chk("setpoint", ramp, setp);
        rv = $urandom;
        obj(1'b1, MWM_IDX_VEL_WINDOW, rv, 32'h0, 1'b0);
        obj(1'b0, MWM_IDX_VEL_WINDOW, 32'h0, {16'h0, rv[15:0]}, 1'b0);
        obj(1'b1, MWM_IDX_VEL_WINDOW, 32'h1E, 32'h0, 1'b0);
        obj(1'b1, MWM_IDX_VEL_DWELL, 32'h2, 32'h0, 1'b0);
        obj(1'b1, MWM_IDX_THR_LEVEL, 32'h1F4, 32'h0, 1'b0);
        obj(1'b1, MWM_IDX_THR_TIME, 32'h1, 32'h0, 1'b0);
        obj(1'b1, MWM_IDX_POS_DWELL, 32'h1, 32'h0, 1'b0);
        m_u.idle();
        mode = MWM_MODE_PROFILE_VEL;
        ramp = 32'sh3E8;
        foreach (voff[k]) begin
            vel_act = 32'sh0;
            wt(2);
            chk("tgt_lapse", 32'h0, tgt);
            chk("nz_idle", 32'h1, nz_n);
            vel_act = 32'sh3E8 + voff[k];
            wt(2 * TK - 1);
            chk("tgt_early", 32'h0, tgt);
            wt(TK + 3);
            chk("tgt_vel", (k < 2) ? 32'h1 : 32'h0, tgt);
            chk("nz_moving", 32'h0, nz_n);
        end
        vel_act = 32'sh3E8;
        wt(3 * TK + 2);
        chk("tgt_vel_in", 32'h1, tgt);
        vel_act = 32'sh3E8 + 32'sh20000;
        wt(1);
        chk("tgt_vel_far", 32'h0, tgt);
        vel_act = 32'sh0;
        foreach (pmode[k]) begin
            mode = pmode[k];
            pos_act = pos_tgt + 32'sh64;
            wt(2);
            chk("tgt_pos_out", 32'h0, tgt);
            pos_act = pos_tgt - 32'sh9;
            wt(TK - 1);
            chk("tgt_pos_early", 32'h0, tgt);
            wt(TK + 3);
            chk("tgt_pos", (k == 1) ? 32'h0 : 32'h1, tgt);
        end
        obj(1'b1, MWM_IDX_POS_WINDOW, 32'h0FFFFFFF, 32'h0, 1'b0);
        m_u.idle();
        wt(3);
        chk("tgt_pos_off", 32'h0, tgt);
        wt(4);
        chk("pending", 32'h0, exq.size());
        close_out();
    end
endmodule // tb

bind mwm_top mwm_monitor mon_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_mode(i_mode),
    .i_vel_actual(i_vel_actual), .i_ramp_out(i_ramp_out), .i_obj_index(i_obj_index),
    .i_obj_rd(i_obj_rd), .i_obj_wr(i_obj_wr), .o_obj_rdata(o_obj_rdata), .o_obj_ack(o_obj_ack),
    .o_obj_err(o_obj_err), .o_target_reached(o_target_reached),
    .o_speed_nonzero_n(o_speed_nonzero_n), .o_vel_setpoint(o_vel_setpoint));
